// ---- dsl_pkg.sv ----
// Purpose: shared constants and types of the drive supervision logic
// Assumes: 25 MHz system clock, frequencies in 0.01 Hz, percents in 0.1 %
// Notes: delays are counted on a 10 ms tick

package dsl_pkg;
   // ***************
   // timing
   // ***************
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_SEC = 1000 / TICK_MS;
   localparam int TW = 20;
   // 0.1 s settings become 10 ms ticks
   localparam logic [19:0] TENTHS_TICKS = 20'h0000A;
   // clamping held this long counts as overheating (5 s)
   localparam logic [19:0] CLAMP_OL_TICKS = 20'h001F4;

   // ***************
   // thresholds
   // ***************
   localparam int FW = 16;
   localparam logic [15:0] SYNC_MIN_FREQ = 16'h2134;   // 85.00 Hz
   localparam logic [3:0] PWM_DEPTH_MAX = 4'hA;
   localparam logic [11:0] OC_THR_MAX = 12'hBB8;       // 300.0 %
   localparam logic [25:0] PCT_FULL = 26'h00003E8;     // 100.0 %
   localparam logic [11:0] SEC_PER_HOUR = 12'hE10;
   localparam logic [15:0] HOURS_MAX = 16'hFFFF;

   // ***************
   // fault codes
   // ***************
   localparam logic [7:0] FAULT_NONE = 8'h00;
   localparam logic [7:0] FAULT_SW_OC = 8'h1F;         // 31
   localparam logic [7:0] FAULT_OVERLOAD = 8'h28;      // 40

   typedef enum {SLP_AWAKE, SLP_ASLEEP} dsl_sleep_e;
   typedef enum {BRK_IDLE, BRK_HOLD, BRK_DONE} dsl_brake_e;
endpackage

// ---- dsl_delay_timer.sv ----
// Purpose: tick-based delay that restarts whenever its condition lapses
// Assumes: tick is a one-cycle pulse on clk
// Notes: a limit of zero expires one cycle after the condition appears
`timescale 1ns/10ps

module dsl_delay_timer #(
   parameter int W = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // timing
   input wire logic tick,
   input wire logic cond,
   input wire logic [W-1:0] limit,
   output logic done_ff
);
   logic [W-1:0] cnt_ff;

   // count stops at the limit, so it never wraps
   always_ff @(posedge clk) begin
      if (srst || !cond) begin
         cnt_ff <= '0;   // [R21]
      end else if (tick && cnt_ff < limit) begin
         cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // expired while the condition still holds
   always_ff @(posedge clk) begin
      if (srst) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= cond && (cnt_ff >= limit);   // [R21]
      end
   end

   restart_clear_a: assert property (@(posedge clk) disable iff (srst)
      !cond |=> !done_ff) else $error("timer done without condition"); // [R21]
endmodule

// ---- dsl_uptime.sv ----
// Purpose: accumulated power-on time in seconds and hours
// Assumes: sec_tick pulses once per second
// Notes: hours saturate rather than wrap
`timescale 1ns/10ps

module dsl_uptime (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // time base
   input wire logic sec_tick,
   // counters
   output logic [11:0] uptime_seconds_ff,
   output logic [15:0] uptime_hours_ff,
   output logic [27:0] uptime_total_ff
);
   localparam logic [11:0] SEC_PER_HOUR = dsl_pkg::SEC_PER_HOUR;

   logic sec_wrap;

   assign sec_wrap = uptime_seconds_ff == (SEC_PER_HOUR - 12'h001);

   // seconds part rolls into hours at 3600
   always_ff @(posedge clk) begin
      if (srst) begin
         uptime_seconds_ff <= 12'h000;
         uptime_hours_ff <= 16'h0000;
      end else if (sec_tick) begin
         if (sec_wrap) begin
            uptime_seconds_ff <= 12'h000;   // [R20]
            if (uptime_hours_ff != dsl_pkg::HOURS_MAX) begin
               uptime_hours_ff <= uptime_hours_ff + 16'h0001;   // [R20]
            end
         end else begin
            uptime_seconds_ff <= uptime_seconds_ff + 12'h001;
         end
      end
   end

   // total in seconds, one cycle behind the parts
   always_ff @(posedge clk) begin
      if (srst) begin
         uptime_total_ff <= 28'h0000000;
      end else begin
         uptime_total_ff <= 28'(uptime_hours_ff) * 28'(SEC_PER_HOUR)
            + {16'h0000, uptime_seconds_ff};   // [R19]
      end
   end

   sec_range_a: assert property (@(posedge clk) disable iff (srst)
      uptime_seconds_ff < SEC_PER_HOUR) else $error("seconds past an hour"); // [R20]
   hour_step_a: assert property (@(posedge clk) disable iff (srst)
      sec_tick && sec_wrap && uptime_hours_ff != 16'hFFFF
      |=> uptime_hours_ff == $past(uptime_hours_ff) + 16'h0001)
      else $error("hours did not advance"); // [R20]
endmodule

// ---- dsl_supervisor.sv ----
// Purpose: supervisory logic of the motor drive: indications, modulation,
//    protection, sleep and wake, fan, brake and power-on time
// Assumes: all inputs come from logic on clk; parameters held stable
// Notes: frequencies 0.01 Hz, percents 0.1 %, oc delays 0.01 s, others 0.1 s
//
// Contract
// [R1] reached output while within band of set
// [R2] depth zero disables random pwm, else 1-10
// [R3] synchronous modulation only above 85 Hz
// [R4] fast clamp enable, reset default enabled
// [R5] long clamping raises overload fault 40, stops
// [R6] sleep after set freq low for delay
// [R7] wake after set freq high for delay
// [R8] both frequencies zero disables sleep and wake
// [R9] wake between sleep and max, sleep below wake
// [R10] pid runs in sleep only if enabled
// [R11] overcurrent beyond delay raises fault 31
// [R12] zero trip delay means no detection
// [R13] overcurrent indication output after its delay
// [R14] dead-time compensation enable, default on
// [R15] fan runs while running or always
// [R16] brake on below start freq, off after hold
// [R17] brake inactive throughout startup
// [R18] skip frequencies during ramps only if mode 1
// [R19] uptime kept as seconds plus hours, summed
// [R20] seconds roll at 3600, hours saturate
// [R21] delay timers restart when condition lapses
`timescale 1ns/10ps

module dsl_supervisor #(
   parameter int TICK_CYCLES = dsl_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // drive state
   input wire logic run_cmd,
   input wire logic running,
   input wire logic starting,
   input wire logic stopping,
   input wire logic clamp_active,
   input wire logic freq_src_pid,
   input wire logic fault_clear,
   input wire logic [15:0] run_freq,
   input wire logic [15:0] set_freq,
   input wire logic [11:0] out_current,
   // parameters
   input wire logic [15:0] max_freq_limit,
   input wire logic [9:0] freq_reach_band,
   input wire logic [3:0] random_pwm_depth,
   input wire logic modulation_select,
   input wire logic fast_current_clamp_en,
   input wire logic [15:0] wake_freq,
   input wire logic [15:0] wake_delay,
   input wire logic [15:0] sleep_freq,
   input wire logic [15:0] sleep_delay,
   input wire logic pid_run_when_stopped,
   input wire logic [11:0] sw_oc_threshold,
   input wire logic [19:0] sw_oc_trip_delay,
   input wire logic [19:0] oc_indicate_delay,
   input wire logic deadtime_comp_en,
   input wire logic fan_policy,
   input wire logic [15:0] ext_brake_start_freq,
   input wire logic [15:0] ext_brake_hold_time,
   input wire logic skip_freq_ramp_mode,
   // terminals and power stage
   output logic freq_reached_ff,
   output logic random_pwm_en_ff,
   output logic [3:0] random_depth_ff,
   output logic sync_mod_ff,
   output logic clamp_en_ff,
   output logic deadtime_comp_ff,
   output logic skip_during_ramp_ff,
   output logic fan_on_ff,
   output logic brake_ff,
   output logic oc_indicate_ff,
   output logic pid_active_ff,
   // run control and faults
   output logic sleep_ff,
   output logic drive_run_ff,
   output logic drive_stop_ff,
   output logic [7:0] fault_code_ff,
   // power-on time
   output logic [11:0] uptime_seconds_ff,
   output logic [15:0] uptime_hours_ff,
   output logic [27:0] uptime_total_ff
);
   localparam int TCW = $clog2(TICK_CYCLES);
   localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
   localparam logic [6:0] SEC_LAST = 7'(dsl_pkg::TICKS_PER_SEC - 1);
   localparam logic [15:0] SYNC_MIN_FREQ = dsl_pkg::SYNC_MIN_FREQ;

   logic [TCW-1:0] tick_cnt_ff;
   logic tick_ff;
   logic [6:0] sec_cnt_ff;
   logic sec_tick_ff;
   logic [15:0] freq_diff;
   logic [25:0] band_hz;
   logic reach_now;
   logic [15:0] eff_sleep;
   logic [15:0] eff_wake;
   logic sleep_en;
   logic sleep_cond;
   logic wake_cond;
   logic sleep_done;
   logic wake_done;
   dsl_pkg::dsl_sleep_e sleep_st_ff;
   logic [11:0] oc_thr;
   logic oc_now;
   logic oc_trip_done;
   logic oc_ind_done;
   logic clamp_ol_done;
   logic sw_oc_fault_ff;
   logic ol_fault_ff;
   dsl_pkg::dsl_brake_e brake_st_ff;
   logic brake_done;

   // ***************
   // time base
   // ***************

   // 10 ms tick shared by all delays; one divider instead of many wide ones
   always_ff @(posedge clk) begin
      if (srst || tick_cnt_ff == TICK_LAST) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + {{(TCW-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= tick_cnt_ff == TICK_LAST;
      end
   end

   // one second from the tick
   always_ff @(posedge clk) begin
      if (srst) begin
         sec_cnt_ff <= 7'h00;
         sec_tick_ff <= 1'b0;
      end else begin
         sec_tick_ff <= tick_ff && sec_cnt_ff == SEC_LAST;
         if (tick_ff) begin
            sec_cnt_ff <= (sec_cnt_ff == SEC_LAST) ? 7'h00 : sec_cnt_ff + 7'h01;
         end
      end
   end

   // ***************
   // indications and modulation
   // ***************

   // band is a share of maximum frequency
   always_comb begin
      freq_diff = (run_freq >= set_freq) ? run_freq - set_freq : set_freq - run_freq;
      band_hz = 26'(max_freq_limit) * 26'(freq_reach_band) / dsl_pkg::PCT_FULL;
      reach_now = {10'h000, freq_diff} <= band_hz;   // [R1]
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         freq_reached_ff <= 1'b0;
      end else begin
         freq_reached_ff <= reach_now;   // [R1]
      end
   end

   // depths above ten are held at ten
   always_ff @(posedge clk) begin
      if (srst) begin
         random_pwm_en_ff <= 1'b0;
         random_depth_ff <= 4'h0;
      end else begin
         random_pwm_en_ff <= random_pwm_depth != 4'h0;   // [R2]
         random_depth_ff <= (random_pwm_depth > dsl_pkg::PWM_DEPTH_MAX) ?
            dsl_pkg::PWM_DEPTH_MAX : random_pwm_depth;   // [R2]
      end
   end

   // synchronous mode falls back to asynchronous at low speed
   always_ff @(posedge clk) begin
      if (srst) begin
         sync_mod_ff <= 1'b0;
      end else begin
         sync_mod_ff <= modulation_select && run_freq > SYNC_MIN_FREQ;   // [R3]
      end
   end

   // plain settings forwarded to the power stage
   always_ff @(posedge clk) begin
      if (srst) begin
         clamp_en_ff <= 1'b1;   // [R4]
         deadtime_comp_ff <= 1'b1;   // [R14]
         skip_during_ramp_ff <= 1'b0;
      end else begin
         clamp_en_ff <= fast_current_clamp_en;   // [R4]
         deadtime_comp_ff <= deadtime_comp_en;   // [R14]
         skip_during_ramp_ff <= skip_freq_ramp_mode;   // [R18]
      end
   end

   // fan follows running unless told to run always
   always_ff @(posedge clk) begin
      if (srst) begin
         fan_on_ff <= 1'b0;
      end else begin
         fan_on_ff <= fan_policy || running;   // [R15]
      end
   end

   // ***************
   // sleep and wake
   // ***************

   // wake is pulled into [sleep, max]; sleep never above wake
   always_comb begin
      eff_sleep = (sleep_freq > wake_freq) ? wake_freq : sleep_freq;   // [R9]
      if (wake_freq > max_freq_limit) begin
         eff_wake = max_freq_limit;   // [R9]
      end else if (wake_freq < eff_sleep) begin
         eff_wake = eff_sleep;
      end else begin
         eff_wake = wake_freq;
      end
      sleep_en = (wake_freq != 16'h0000) || (sleep_freq != 16'h0000);   // [R8]
      sleep_cond = sleep_en && sleep_st_ff == dsl_pkg::SLP_AWAKE && running
         && set_freq <= eff_sleep;   // [R6]
      wake_cond = sleep_en && sleep_st_ff == dsl_pkg::SLP_ASLEEP && run_cmd
         && set_freq >= eff_wake;   // [R7]
   end

   dsl_delay_timer #(.W(dsl_pkg::TW)) u_sleep_tmr (
      .clk(clk),
      .srst(srst),
      .tick(tick_ff),
      .cond(sleep_cond),
      .limit(20'(sleep_delay * dsl_pkg::TENTHS_TICKS)),
      .done_ff(sleep_done)
   );

   dsl_delay_timer #(.W(dsl_pkg::TW)) u_wake_tmr (
      .clk(clk),
      .srst(srst),
      .tick(tick_ff),
      .cond(wake_cond),
      .limit(20'(wake_delay * dsl_pkg::TENTHS_TICKS)),
      .done_ff(wake_done)
   );

   // dropping the run command ends sleep; the drive is stopped anyway
   always_ff @(posedge clk) begin
      if (srst) begin
         sleep_st_ff <= dsl_pkg::SLP_AWAKE;
      end else begin
         case (sleep_st_ff)
            dsl_pkg::SLP_AWAKE: begin
               if (sleep_done && sleep_cond) begin
                  sleep_st_ff <= dsl_pkg::SLP_ASLEEP;   // [R6]
               end
            end
            dsl_pkg::SLP_ASLEEP: begin
               if (!sleep_en || !run_cmd || (wake_done && wake_cond)) begin
                  sleep_st_ff <= dsl_pkg::SLP_AWAKE;   // [R7] [R8]
               end
            end
            default: sleep_st_ff <= dsl_pkg::SLP_AWAKE;
         endcase
      end
   end

   // pid keeps working in sleep only when allowed to run at stop
   always_ff @(posedge clk) begin
      if (srst) begin
         pid_active_ff <= 1'b0;
      end else if (sleep_st_ff == dsl_pkg::SLP_ASLEEP) begin
         pid_active_ff <= freq_src_pid && pid_run_when_stopped;   // [R10]
      end else begin
         pid_active_ff <= freq_src_pid && running;
      end
   end

   // ***************
   // protection
   // ***************

   always_comb begin
      oc_thr = (sw_oc_threshold > dsl_pkg::OC_THR_MAX) ? dsl_pkg::OC_THR_MAX
         : sw_oc_threshold;
      oc_now = out_current >= oc_thr;
   end

   dsl_delay_timer #(.W(dsl_pkg::TW)) u_oc_trip_tmr (
      .clk(clk),
      .srst(srst),
      .tick(tick_ff),
      .cond(oc_now && sw_oc_trip_delay != 20'h00000),   // [R12]
      .limit(sw_oc_trip_delay),
      .done_ff(oc_trip_done)
   );

   dsl_delay_timer #(.W(dsl_pkg::TW)) u_oc_ind_tmr (
      .clk(clk),
      .srst(srst),
      .tick(tick_ff),
      .cond(oc_now && oc_indicate_delay != 20'h00000),   // [R13]
      .limit(oc_indicate_delay),
      .done_ff(oc_ind_done)
   );

   // overheating is judged by how long clamping lasts
   dsl_delay_timer #(.W(dsl_pkg::TW)) u_clamp_tmr (
      .clk(clk),
      .srst(srst),
      .tick(tick_ff),
      .cond(clamp_active && fast_current_clamp_en),
      .limit(dsl_pkg::CLAMP_OL_TICKS),
      .done_ff(clamp_ol_done)
   );

   // sticky faults; a new trip wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         sw_oc_fault_ff <= 1'b0;
         ol_fault_ff <= 1'b0;
      end else begin
         sw_oc_fault_ff <= oc_trip_done || (sw_oc_fault_ff && !fault_clear);   // [R11]
         ol_fault_ff <= clamp_ol_done || (ol_fault_ff && !fault_clear);   // [R5]
      end
   end

   // overload reported first when both are pending
   always_ff @(posedge clk) begin
      if (srst) begin
         fault_code_ff <= dsl_pkg::FAULT_NONE;
      end else if (ol_fault_ff) begin
         fault_code_ff <= dsl_pkg::FAULT_OVERLOAD;   // [R5]
      end else if (sw_oc_fault_ff) begin
         fault_code_ff <= dsl_pkg::FAULT_SW_OC;   // [R11]
      end else begin
         fault_code_ff <= dsl_pkg::FAULT_NONE;
      end
   end

   // indication is a level, no latching
   always_ff @(posedge clk) begin
      if (srst) begin
         oc_indicate_ff <= 1'b0;
      end else begin
         oc_indicate_ff <= oc_ind_done;   // [R13]
      end
   end

   // run permission folds sleep and faults together
   always_ff @(posedge clk) begin
      if (srst) begin
         sleep_ff <= 1'b0;
         drive_run_ff <= 1'b0;
         drive_stop_ff <= 1'b0;
      end else begin
         sleep_ff <= sleep_st_ff == dsl_pkg::SLP_ASLEEP;
         drive_stop_ff <= ol_fault_ff || sw_oc_fault_ff
            || sleep_st_ff == dsl_pkg::SLP_ASLEEP;   // [R5] [R6]
         drive_run_ff <= run_cmd && !ol_fault_ff && !sw_oc_fault_ff
            && sleep_st_ff == dsl_pkg::SLP_AWAKE;   // [R7]
      end
   end

   // ***************
   // external brake
   // ***************

   dsl_delay_timer #(.W(dsl_pkg::TW)) u_brake_tmr (
      .clk(clk),
      .srst(srst),
      .tick(tick_ff),
      .cond(brake_st_ff == dsl_pkg::BRK_HOLD),
      .limit(20'(ext_brake_hold_time * dsl_pkg::TENTHS_TICKS)),
      .done_ff(brake_done)
   );

   // one brake pulse per stop; a new start cancels it at once
   always_ff @(posedge clk) begin
      if (srst) begin
         brake_st_ff <= dsl_pkg::BRK_IDLE;
      end else begin
         case (brake_st_ff)
            dsl_pkg::BRK_IDLE: begin
               if (stopping && !starting && run_freq < ext_brake_start_freq) begin
                  brake_st_ff <= dsl_pkg::BRK_HOLD;   // [R16]
               end
            end
            dsl_pkg::BRK_HOLD: begin
               if (starting) begin
                  brake_st_ff <= dsl_pkg::BRK_IDLE;   // [R17]
               end else if (brake_done) begin
                  brake_st_ff <= dsl_pkg::BRK_DONE;   // [R16]
               end
            end
            dsl_pkg::BRK_DONE: begin
               if (!stopping || starting) begin
                  brake_st_ff <= dsl_pkg::BRK_IDLE;
               end
            end
            default: brake_st_ff <= dsl_pkg::BRK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         brake_ff <= 1'b0;
      end else begin
         brake_ff <= brake_st_ff == dsl_pkg::BRK_HOLD && !starting;   // [R16] [R17]
      end
   end

   // ***************
   // power-on time
   // ***************

   dsl_uptime u_uptime (
      .clk(clk),
      .srst(srst),
      .sec_tick(sec_tick_ff),
      .uptime_seconds_ff(uptime_seconds_ff),
      .uptime_hours_ff(uptime_hours_ff),
      .uptime_total_ff(uptime_total_ff)
   );

   // ***************
   // checks
   // ***************

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence brk_enter_s;
      brake_st_ff == dsl_pkg::BRK_IDLE && stopping && !starting
         && run_freq < ext_brake_start_freq;
   endsequence

   reach_equal_a: assert property (run_freq == set_freq |=> freq_reached_ff)
      else $error("reached flag missing at equal freq"); // [R1]
   pwm_off_a: assert property (random_pwm_depth == 4'h0 |=> !random_pwm_en_ff)
      else $error("random pwm on at zero depth"); // [R2]
   sync_low_a: assert property (run_freq <= SYNC_MIN_FREQ |=> !sync_mod_ff)
      else $error("sync modulation at low freq"); // [R3]
   ol_trip_a: assert property (clamp_ol_done |=> ##1 fault_code_ff == 8'h28)
      else $error("overload fault not raised"); // [R5]
   sleep_entry_a: assert property (sleep_done && sleep_cond |=> ##1 sleep_ff)
      else $error("sleep not entered"); // [R6]
   sleep_off_a: assert property (!sleep_en |=> sleep_st_ff == dsl_pkg::SLP_AWAKE)
      else $error("sleep while disabled"); // [R8]
   oc_nodet_a: assert property (sw_oc_trip_delay == 20'h00000 && !sw_oc_fault_ff
      |=> !sw_oc_fault_ff) else $error("trip with zero delay"); // [R12]
   ind_zero_a: assert property (oc_indicate_delay == 20'h00000 |=> ##1 !oc_indicate_ff)
      else $error("indication with zero delay"); // [R13]
   fan_policy_a: assert property (fan_policy |=> fan_on_ff)
      else $error("fan off under continuous policy"); // [R15]
   brake_on_a: assert property (brk_enter_s ##1 !starting |=> brake_ff)
      else $error("brake not applied at stop"); // [R16]
   brake_start_a: assert property (starting |=> !brake_ff)
      else $error("brake active during startup"); // [R17]
endmodule

// ---- dsl_stage_model.sv ----
// Purpose: power stage model facing the supervisor
// Assumes: run_cmd and overdrive come from the bench
// Notes: the limiter only engages while it is enabled
`timescale 1ns/10ps

module dsl_stage_model (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // commands
   input wire logic run_cmd,
   input wire logic overdrive,
   input wire logic drive_run_ff,
   input wire logic drive_stop_ff,
   input wire logic clamp_en_ff,
   // stage state
   output logic running,
   output logic clamp_active
);
   // motor turns only while permitted and not told to stop
   always_ff @(posedge clk) begin
      running <= !srst && run_cmd && drive_run_ff && !drive_stop_ff;
   end
   // a disabled limiter lets the current through instead
   always_ff @(posedge clk) begin
      clamp_active <= !srst && overdrive && clamp_en_ff;
   end
endmodule

// ---- drive_supervision_logic_tb.sv ----
// Purpose: self-checking bench of the supervisor
// Assumes: tick shortened to 10 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/10ps

module drive_supervision_logic_tb;
   logic clk, srst, run_cmd, running, starting, stopping, clamp_active;
   logic freq_src_pid, fault_clear, overdrive, modulation_select, fast_current_clamp_en;
   logic pid_run_when_stopped, deadtime_comp_en, fan_policy, skip_freq_ramp_mode;
   logic [15:0] run_freq, set_freq, max_freq_limit, wake_freq, wake_delay, sleep_freq;
   logic [15:0] sleep_delay, ext_brake_start_freq, ext_brake_hold_time, uptime_hours_ff;
   logic [11:0] out_current, sw_oc_threshold, uptime_seconds_ff, s0;
   logic [9:0] freq_reach_band;
   logic [3:0] random_pwm_depth, random_depth_ff;
   logic [19:0] sw_oc_trip_delay, oc_indicate_delay;
   logic freq_reached_ff, random_pwm_en_ff, sync_mod_ff, clamp_en_ff, deadtime_comp_ff;
   logic skip_during_ramp_ff, fan_on_ff, brake_ff, oc_indicate_ff, pid_active_ff;
   logic sleep_ff, drive_run_ff, drive_stop_ff, f31, f40;
   logic [7:0] fault_code_ff;
   logic [27:0] uptime_total_ff;
   int fails, cmp_count, k;
   assign f31 = fault_code_ff === dsl_pkg::FAULT_SW_OC;
   assign f40 = fault_code_ff === dsl_pkg::FAULT_OVERLOAD;
   dsl_supervisor #(.TICK_CYCLES(10)) u_dut (.*);
   dsl_stage_model u_stage (.*);
   // free-running system clock
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string nm, input int e, input logic [27:0] g);
      cmp_count++;
      if (g !== e[27:0]) begin
         fails++;
         $display("MISMATCH %s exp %0h got %0h", nm, e, g);
      end
   endtask
   // a wait that runs out ends the run
   task automatic wt(ref logic s, input logic v, input int n, input string nm);
      for (int i = 0; i < n && s !== v; i++) begin
         cyc(1);
      end
      chk(nm, v, s);
      if (s !== v) complete_run;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ***
   // scenarios
   // ***
   task t_mode;
      chk("clamp_rst", 1, clamp_en_ff);
      chk("dt_rst", 1, deadtime_comp_ff);
      {fast_current_clamp_en, deadtime_comp_en, skip_freq_ramp_mode} = 3'h1;
      cyc(2);
      chk("clamp_off", 0, clamp_en_ff);
      chk("dt_off", 0, deadtime_comp_ff);
      chk("skip_on", 1, skip_during_ramp_ff);
      {fast_current_clamp_en, deadtime_comp_en, skip_freq_ramp_mode} = 3'h6;
      random_pwm_depth = 4'h0;
      modulation_select = 1;
      run_freq = 16'h2134;
      cyc(2);
      chk("pwm_off", 0, random_pwm_en_ff);
      chk("sync_85", 0, sync_mod_ff);
      run_freq = 16'h2135;
      cyc(2);
      chk("sync_hi", 1, sync_mod_ff);
      modulation_select = 0;
      for (k = 1; k <= 10; k++) begin
         random_pwm_depth = k[3:0];
         cyc(2);
         chk("pwm_on", 1, random_pwm_en_ff);
         chk("pwm_depth", k, random_depth_ff);
      end
      chk("sync_async", 0, sync_mod_ff);
      $display("test modes done");
   endtask
   task t_reach;
      max_freq_limit = 16'h2710;
      freq_reach_band = 10'h00A;
      set_freq = 16'h1388;
      for (k = 0; k < 3; k++) begin
         run_freq = k == 0 ? 16'h13EC : k == 1 ? 16'h1324 : 16'h13ED;
         cyc(2);
         chk("reach", k < 2, freq_reached_ff);
      end
      $display("test reach done");
   endtask
   task t_fan;
      cyc(2);
      chk("fan_idle", 0, fan_on_ff);
      run_cmd = 1;
      wt(fan_on_ff, 1, 6, "fan_run");
      run_cmd = 0;
      fan_policy = 1;
      cyc(6);
      chk("fan_always", 1, fan_on_ff);
      fan_policy = 0;
      $display("test fan done");
   endtask
   task t_oc;
      sw_oc_threshold = 12'h064;
      sw_oc_trip_delay = 20'h00003;
      oc_indicate_delay = 20'h00003;
      // three short bursts must not add up
      repeat (3) begin
         out_current = 12'h064;
         cyc(15);
         out_current = 12'h063;
         cyc(5);
      end
      chk("oc_burst", 0, fault_code_ff);
      chk("ind_burst", 0, oc_indicate_ff);
      out_current = 12'h064;
      wt(oc_indicate_ff, 1, 60, "ind_on");
      wt(f31, 1, 60, "oc_trip");
      out_current = 12'h000;
      wt(oc_indicate_ff, 0, 5, "ind_off");
      fault_clear = 1;
      cyc(1);
      fault_clear = 0;
      cyc(2);
      chk("oc_clear", 0, fault_code_ff);
      {sw_oc_trip_delay, oc_indicate_delay} = '0;
      out_current = 12'h064;
      cyc(80);
      chk("oc_none", 0, fault_code_ff);
      chk("ind_none", 0, oc_indicate_ff);
      out_current = 12'h000;
      overdrive = 1;
      cyc(4880);
      chk("ovl_early", 0, fault_code_ff);
      wt(f40, 1, 300, "ovl_trip");
      chk("ovl_stop", 1, drive_stop_ff);
      overdrive = 0;
      fault_clear = 1;
      cyc(4);
      fault_clear = 0;
      cyc(2);
      chk("ovl_clear", 0, fault_code_ff);
      $display("test overcurrent done");
   endtask
   task t_brake;
      {ext_brake_start_freq, ext_brake_hold_time} = {16'h01F4, 16'h0001};
      {stopping, starting, run_freq} = {2'h3, 16'h0001};
      cyc(6);
      chk("brk_start", 0, brake_ff);
      {stopping, starting, run_freq} = {2'h2, 16'h01F4};
      cyc(3);
      chk("brk_above", 0, brake_ff);
      run_freq = 16'h01F3;
      wt(brake_ff, 1, 3, "brk_on");
      cyc(80);
      chk("brk_hold", 1, brake_ff);
      wt(brake_ff, 0, 40, "brk_off");
      stopping = 0;
      $display("test brake done");
   endtask
   task t_sleep;
      {wake_freq, sleep_freq, wake_delay, sleep_delay} = {16'h07D0, 16'h03E8, 32'h00010001};
      {run_cmd, freq_src_pid, pid_run_when_stopped, set_freq} = {3'h7, 16'h0BB8};
      cyc(6);
      chk("pid_run", 1, pid_active_ff);
      set_freq = 16'h03E8;
      cyc(80);
      chk("slp_early", 0, sleep_ff);
      wt(sleep_ff, 1, 40, "slp_on");
      chk("slp_stop", 1, drive_stop_ff);
      cyc(2);
      chk("pid_slp", 1, pid_active_ff);
      pid_run_when_stopped = 0;
      cyc(2);
      chk("pid_off", 0, pid_active_ff);
      set_freq = 16'h07D0;
      cyc(80);
      chk("wake_early", 1, sleep_ff);
      wt(sleep_ff, 0, 40, "wake");
      {wake_freq, sleep_freq, set_freq} = '0;
      cyc(200);
      chk("slp_dis", 0, sleep_ff);
      run_cmd = 0;
      $display("test sleep done");
   endtask
   task t_uptime;
      s0 = uptime_seconds_ff;
      for (k = 0; k < 1100 && uptime_seconds_ff === s0; k++) begin
         cyc(1);
      end
      cyc(3);
      chk("up_sec", s0 + 1, uptime_seconds_ff);
      chk("up_hrs", 0, uptime_hours_ff);
      chk("up_total", s0 + 1, uptime_total_ff);
      $display("test uptime done");
   endtask
   // reset, then every scenario in turn
   initial begin
      {run_cmd, starting, stopping, freq_src_pid, fault_clear, overdrive} = '0;
      {run_freq, set_freq, out_current, freq_reach_band, random_pwm_depth} = '0;
      {wake_freq, wake_delay, sleep_freq, sleep_delay, pid_run_when_stopped} = '0;
      {ext_brake_start_freq, ext_brake_hold_time, fan_policy, modulation_select} = '0;
      {sw_oc_trip_delay, oc_indicate_delay, skip_freq_ramp_mode} = '0;
      {fast_current_clamp_en, deadtime_comp_en, sw_oc_threshold} = {2'h3, 12'h7D0};
      max_freq_limit = 16'h2710;
      srst = 1;
      fails = 0;
      cmp_count = 0;
      cyc(12);
      srst = 0;
      cyc(2);
      t_mode;
      t_reach;
      t_fan;
      t_oc;
      t_brake;
      t_sleep;
      t_uptime;
      complete_run;
   end
endmodule
